// [bench/testbench.sv]
// Self-checking bench for the EEPROM read engine with a behavioural master.
// Assumes the package and defines header are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "ee_read_defines.svh"

`define CHK(nm, exp, got) begin samples_checked++; if ((got) !== (exp)) begin \
  miscompares++; $display("wrong value %s expected %h seen %h", nm, exp, got); end end

module testbench;
  import ee_read_pkg::*;
  localparam int         TWR    = 400;
  localparam logic [2:0] STRAPS = 3'h5;
  logic        clk, arst_n, scl, pull, sda, sda_o, sda_oe;
  logic        wr_valid, wr_ready, busy;
  logic [12:0] rd_addr, rd_addr_s;
  logic [7:0]  rd_data, rd_data_s;
  logic [2:0]  straps;
  logic        sda_o_s, sda_oe_s;
  wr_item_type item;
  int          miscompares, samples_checked;

  // Memory contents derived from the address; the high bits fold into the low byte
  function automatic logic [7:0] mem_byte(input logic [12:0] a);
    return a[7:0] ^ {3'h0, a[12:8]} ^ 8'h5a;
  endfunction
  function automatic logic [7:0] dev(input logic rw);
    return {`EE_DEV_TYPE, straps, rw};
  endfunction
  assign rd_data   = mem_byte(rd_addr);
  assign rd_data_s = mem_byte(rd_addr_s);
  // Open-drain wire with pull-up: low if any party pulls
  assign sda = ~((sda_oe & ~sda_o) | (sda_oe_s & ~sda_o_s) | pull);

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  two_wire_master u_m (.sda_i(sda), .scl_o(scl), .pull_o(pull));

  serial_eeprom_read_engine #(.LARGE_DENSITY(1'b1), .TWR_CYCLES(TWR)) u_dut (
    .clk_sys_i(clk), .arst_n_i(arst_n), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe_o(sda_oe), .chip_select_straps_i(straps), .rd_addr_o(rd_addr),
    .rd_data_i(rd_data), .wr_item_o(item), .wr_valid_o(wr_valid),
    .wr_ready_i(wr_ready), .busy_o(busy));

  // Second target of the smaller density on the same bus, straps inverted
  serial_eeprom_read_engine #(.LARGE_DENSITY(1'b0), .TWR_CYCLES(TWR)) u_dut_small (
    .clk_sys_i(clk), .arst_n_i(arst_n), .scl_i(scl), .sda_i(sda), .sda_o(sda_o_s),
    .sda_oe_o(sda_oe_s), .chip_select_straps_i(~straps), .rd_addr_o(rd_addr_s),
    .rd_data_i(rd_data_s), .wr_item_o(), .wr_valid_o(), .wr_ready_i(wr_ready), .busy_o());

  task automatic results;
    $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic sync;
    @(posedge clk);
    #1;
  endtask
  task automatic tx(input logic [7:0] b, input logic exp_n);
    logic a;
    u_m.put_byte(b, a);
    `CHK("ack_n", exp_n, a)
  endtask
  task automatic rx(input logic [12:0] a, input logic more);
    logic [7:0] d;
    u_m.get_byte(more, d);
    `CHK("rd_byte", mem_byte(a), d)
  endtask
  // Dummy write: device byte and both address bytes, no data
  task automatic set_addr(input logic [12:0] a);
    u_m.bus_start(1'b0);
    tx(dev(1'b0), 1'b0);
    tx({3'h0, a[12:8]}, 1'b0);
    tx(a[7:0], 1'b0);
  endtask
  task automatic wait_idle;
    for (int i = 0; i < 1000 && busy !== 1'b0; i++) sync;
    `CHK("busy", 1'b0, busy)
  endtask

  task automatic t_reset;
    sync;
    `CHK("rd_addr", 13'h0000, rd_addr)
    `CHK("sda_oe", 1'b0, sda_oe)
    `CHK("sda_o", 1'b0, sda_o)
    `CHK("wr_valid", 1'b0, wr_valid)
    `CHK("busy", 1'b0, busy)
  endtask

  // Wrong straps and wrong type code both go unanswered
  task automatic t_refuse;
    sync;
    u_m.bus_start(1'b0);
    tx({`EE_DEV_TYPE, STRAPS ^ 3'h1, 1'b1}, 1'b1);
    u_m.bus_stop;
    u_m.bus_start(1'b0);
    tx({4'h5, STRAPS, 1'b1}, 1'b1);
    u_m.bus_stop;
    `CHK("sda_oe", 1'b0, sda_oe)
    // Other strap levels: the device follows its pins, not a fixed code
    straps = STRAPS ^ 3'h7;
    repeat (3) sync;
    u_m.bus_start(1'b0);
    tx(dev(1'b0), 1'b0);
    u_m.bus_stop;
    straps = STRAPS;
    repeat (3) sync;
  endtask

  // Random read across the top of memory, continued sequentially
  task automatic t_random;
    sync;
    set_addr(13'h1ffe);
    u_m.bus_start(1'b1);
    tx(dev(1'b1), 1'b0);
    rx(13'h1ffe, 1'b1);
    rx(13'h1fff, 1'b1);
    rx(13'h0000, 1'b0);
    `CHK("sda_oe", 1'b0, sda_oe)
    u_m.bus_stop;
    `CHK("sda_oe", 1'b0, sda_oe)
    `CHK("busy", 1'b0, busy)
    `CHK("rd_addr", 13'h0001, rd_addr)
  endtask

  task automatic t_current(input logic [12:0] a);
    sync;
    u_m.bus_start(1'b0);
    tx(dev(1'b1), 1'b0);
    rx(a, 1'b0);
    u_m.bus_stop;
    `CHK("rd_addr", a + 13'h0001, rd_addr)
  endtask

  // Fill the FIFO past its depth inside one page, then drain with stalls
  task automatic t_fill;
    sync;
    wr_ready = 1'b0;
    set_addr(13'h003e);
    for (int i = 0; i < 17; i++) tx(8'(16 + i), i == 16);
    u_m.bus_stop;
    for (int i = 0; i < 16; i++) begin
      repeat (3) @(posedge clk);
      #1 `CHK("wr_valid", 1'b1, wr_valid)
      `CHK("wr_addr", 13'(32 + (30 + i) % 32), item.addr)
      `CHK("wr_data", 8'(16 + i), item.data)
      wr_ready = 1'b1;
      @(posedge clk) #1 wr_ready = 1'b0;
    end
    `CHK("wr_valid", 1'b0, wr_valid)
    `CHK("rd_addr", 13'h002e, rd_addr)
    wait_idle;
  endtask

  // Write interval length, and no answer while it runs
  task automatic t_busy;
    int n;
    n = 0;
    sync;
    wr_ready = 1'b1;
    set_addr(13'h0100);
    tx(8'h77, 1'b0);
    fork
      begin
        for (int i = 0; i < 100 && busy !== 1'b1; i++) sync;
        while (busy === 1'b1 && n < 800) begin
          sync;
          n++;
        end
      end
      begin
        u_m.bus_stop;
        #100 u_m.bus_start(1'b0);
        tx(dev(1'b1), 1'b1);
        u_m.bus_stop;
      end
    join
    `CHK("busy_len", TWR, n)
    wr_ready = 1'b0;
    wait_idle;
  endtask

  // Smaller density: top address bit dropped, reads wrap at its own top
  task automatic t_small;
    sync;
    u_m.bus_start(1'b0);
    tx({`EE_DEV_TYPE, ~straps, 1'b0}, 1'b0);
    tx(8'h1f, 1'b0);
    tx(8'hff, 1'b0);
    u_m.bus_start(1'b1);
    tx({`EE_DEV_TYPE, ~straps, 1'b1}, 1'b0);
    rx(13'h0fff, 1'b1);
    rx(13'h0000, 1'b0);
    u_m.bus_stop;
    `CHK("rd_addr_s", 13'h0001, rd_addr_s)
  endtask

  // Main sequence, then the watchdog that cuts a hang short
  initial begin
    arst_n = 1'b0;
    wr_ready = 1'b0;
    straps = STRAPS;
    miscompares = 0;
    samples_checked = 0;
    repeat (12) @(posedge clk);
    #1 arst_n = 1'b1;
    repeat (4) @(posedge clk);
    t_reset;
    t_refuse;
    t_random;
    t_current(13'h0001);
    t_fill;
    t_busy;
    t_current(13'h0101);
    t_small;
    results;
  end
  initial begin
    #100000;
    miscompares++;
    results;
  end
endmodule // testbench

`default_nettype wire

// [bench/two_wire_master.sv]
// Behavioural two-wire bus master: drives SCL and pulls SDA low on demand.
// Assumes callers enter each task just after a rising system clock edge.
`timescale 1ns/1ps
`default_nettype none

module two_wire_master (
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      pull_o
);
  // Bus idles high; SCL stands still outside frames
  initial begin
    scl_o  = 1'b1;
    pull_o = 1'b0;
  end

  // One bit of 64 ns: data moves in the low phase only, sampled mid-high
  task automatic put_bit(input logic b, output logic s);
    scl_o = 1'b0;
    #8 pull_o = ~b;
    #24 scl_o = 1'b1;
    #16 s = sda_i;
    #16;
  endtask

  // A repeated start needs a low phase first so SDA can rise with SCL low
  task automatic bus_start(input logic rep);
    logic s;
    if (rep) begin
      put_bit(1'b1, s);
    end
    pull_o = 1'b1;
    #32;
  endtask

  // Stop, then keep the bus free long enough for the target to go idle
  task automatic bus_stop;
    logic s;
    put_bit(1'b0, s);
    pull_o = 1'b0;
    #64;
  endtask

  // Byte out MSB first, then line released for the ninth clock
  task automatic put_byte(input logic [7:0] b, output logic ack_n);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      put_bit(b[i], s);
    end
    put_bit(1'b1, ack_n);
  endtask

  // Byte in; acknowledge only when another byte is wanted
  task automatic get_byte(input logic more, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      put_bit(1'b1, d[i]);
    end
    put_bit(~more, s);
  endtask
endmodule // two_wire_master

`default_nettype wire

// [hw/ee_read_defines.svh]
// Constants of the serial EEPROM read engine: offsets, field values, timing.
// Assumes inclusion by bare name from the package and the top module.
`ifndef EE_READ_DEFINES_SVH
`define EE_READ_DEFINES_SVH

`define EE_DEV_TYPE    4'ha
`define EE_ADDR_W      13
`define EE_PAGE_W      5
`define EE_MASK_LARGE  13'h1fff
`define EE_MASK_SMALL  13'h0fff
`define EE_BIT_LAST    4'h8
`define EE_TX_LAST     4'h7
`define EE_FIFO_DEPTH  16
`define EE_BUSY_W      21
`define EE_CLK_MHZ     250
`define EE_TWR_MS      5
// Longest write interval in clock cycles, rounded down
`define EE_TWR_CYC     (`EE_TWR_MS * 1000 * `EE_CLK_MHZ)

`endif

// [hw/ee_read_pkg.sv]
// Types shared by the serial EEPROM read engine and its bench.
// Assumes the defines header sits next to it.
`include "ee_read_defines.svh"

package ee_read_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RX   = 3'b001,
    ST_ACK  = 3'b010,
    ST_TX   = 3'b011,
    ST_MACK = 3'b100
  } phase_type;

  typedef enum logic [1:0] {
    KIND_DEV  = 2'b00,
    KIND_AHI  = 2'b01,
    KIND_ALO  = 2'b10,
    KIND_DATA = 2'b11
  } kind_type;

  typedef struct packed {
    logic [`EE_ADDR_W-1:0] addr;
    logic [7:0]            data;
  } wr_item_type;

endpackage

// [hw/serial_eeprom_read_engine.sv]
// Two-wire EEPROM target: address counter, reads, write capture, write interval.
// Assumes SCL and SDA arrive asynchronous; memory array outside answers rd_addr_o.
`timescale 1ns/1ps
`default_nettype none
`include "ee_read_defines.svh"

module serial_eeprom_read_engine
  import ee_read_pkg::*;
#(
  parameter bit          LARGE_DENSITY = 1'b1,
  parameter int unsigned TWR_CYCLES    = `EE_TWR_CYC
) (
  input  wire logic                  clk_sys_i,
  input  wire logic                  arst_n_i,
  input  wire logic                  scl_i,
  input  wire logic                  sda_i,
  output logic                       sda_o,
  output logic                       sda_oe_o,
  input  wire logic [2:0]            chip_select_straps_i,
  output logic [`EE_ADDR_W-1:0]      rd_addr_o,
  input  wire logic [7:0]            rd_data_i,
  output wr_item_type                wr_item_o,
  output logic                       wr_valid_o,
  input  wire logic                  wr_ready_i,
  output logic                       busy_o
);
  localparam logic [`EE_ADDR_W-1:0] ADDR_MASK =
    LARGE_DENSITY ? `EE_MASK_LARGE : `EE_MASK_SMALL;
  localparam logic [`EE_BUSY_W-1:0] TWR_LOAD = TWR_CYCLES[`EE_BUSY_W-1:0];

  logic [4:0]                 pin_raw;
  logic [4:0]                 meta_r;
  logic [4:0]                 sync_r;
  logic                       scl_d_r;
  logic                       sda_d_r;
  logic                       scl_s;
  logic                       sda_s;
  logic [2:0]                 straps_s;
  logic                       scl_rise;
  logic                       scl_fall;
  logic                       start_ev;
  logic                       stop_ev;
  phase_type                  phase_r;
  kind_type                   kind_r;
  logic [3:0]                 bcnt_r;
  logic [7:0]                 sh_r;
  logic [7:0]                 tx_r;
  logic                       rd_mode_r;
  logic                       sda_oe_r;
  logic [`EE_PAGE_W-1:0]      ahi_r;
  logic [`EE_ADDR_W-1:0]      addr_r;
  logic                       wrote_r;
  logic [`EE_BUSY_W-1:0]      busy_cnt_r;
  logic                       dev_match;
  logic                       decide;
  logic                       ack_ok;
  logic                       ack_end;
  logic                       load_tx;
  logic                       push;
  logic                       fifo_rdy;
  wr_item_type                push_item;

  // Two flops per pin; only the second stage feeds logic
  assign pin_raw = {chip_select_straps_i, sda_i, scl_i};
  for (genvar g = 0; g < 5; g++) begin : g_sync
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        meta_r[g] <= 1'b1;
        sync_r[g] <= 1'b1;
      end else begin
        meta_r[g] <= pin_raw[g];
        sync_r[g] <= meta_r[g];
      end
    end
  end

  // Previous synced levels for edge and condition detection
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end

  // Bus events; start and stop need SCL high on both samples
  assign scl_s    = sync_r[0];
  assign sda_s    = sync_r[1];
  assign straps_s = sync_r[4:2];
  assign scl_rise = scl_s && !scl_d_r;
  assign scl_fall = !scl_s && scl_d_r;
  assign start_ev = scl_s && scl_d_r && sda_d_r && !sda_s;
  assign stop_ev  = scl_s && scl_d_r && !sda_d_r && sda_s;

  // Byte decisions; a busy array answers no device address at all
  assign dev_match = (sh_r[7:4] == `EE_DEV_TYPE) && (sh_r[3:1] == straps_s) &&
                     (busy_cnt_r == '0);
  assign decide    = (phase_r == ST_RX) && scl_fall && (bcnt_r == `EE_BIT_LAST);
  assign ack_ok    = (kind_r == KIND_DEV)  ? dev_match :
                     (kind_r == KIND_DATA) ? fifo_rdy : 1'b1;
  assign ack_end   = (phase_r == ST_ACK) && scl_fall;
  assign load_tx   = (ack_end && rd_mode_r) || ((phase_r == ST_MACK) && scl_fall);
  assign push      = decide && (kind_r == KIND_DATA) && fifo_rdy;

  // Counter steps: reads wrap at top of memory, writes inside the page
  function automatic logic [`EE_ADDR_W-1:0] inc_rd(input logic [`EE_ADDR_W-1:0] a);
    inc_rd = (a + 1'b1) & ADDR_MASK;
  endfunction

  function automatic logic [`EE_ADDR_W-1:0] inc_wr(input logic [`EE_ADDR_W-1:0] a);
    logic [`EE_PAGE_W-1:0] low;
    low    = a[`EE_PAGE_W-1:0] + 1'b1;
    inc_wr = {a[`EE_ADDR_W-1:`EE_PAGE_W], low};
  endfunction

  // Bus phase machine; start and stop override any phase
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      phase_r   <= ST_IDLE;
      kind_r    <= KIND_DEV;
      bcnt_r    <= '0;
      rd_mode_r <= 1'b0;
    end else if (start_ev) begin
      phase_r   <= ST_RX;
      kind_r    <= KIND_DEV;
      bcnt_r    <= '0;
      rd_mode_r <= 1'b0;
    end else if (stop_ev) begin
      phase_r <= ST_IDLE;
    end else begin
      case (phase_r)
        ST_RX: begin
          if (scl_rise) begin
            bcnt_r <= bcnt_r + 1'b1;
          end else if (decide) begin
            phase_r <= ack_ok ? ST_ACK : ST_IDLE;
            if (kind_r == KIND_DEV) begin
              rd_mode_r <= sh_r[0];
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            bcnt_r  <= '0;
            phase_r <= rd_mode_r ? ST_TX : ST_RX;
            case (kind_r)
              KIND_DEV: kind_r <= KIND_AHI;
              KIND_AHI: kind_r <= KIND_ALO;
              default:  kind_r <= KIND_DATA;
            endcase
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (bcnt_r == `EE_TX_LAST) begin
              bcnt_r  <= '0;
              phase_r <= ST_MACK;
            end else begin
              bcnt_r <= bcnt_r + 1'b1;
            end
          end
        end
        ST_MACK: begin
          if (scl_rise && sda_s) begin
            phase_r <= ST_IDLE;
          end else if (scl_fall) begin
            phase_r <= ST_TX;
          end
        end
        default: phase_r <= ST_IDLE;
      endcase
    end
  end

  // Shifting and data line drive; drive changes only after SCL falls
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sh_r     <= '0;
      tx_r     <= '0;
      sda_oe_r <= 1'b0;
    end else if (start_ev || stop_ev) begin
      sda_oe_r <= 1'b0;
    end else begin
      if ((phase_r == ST_RX) && scl_rise) begin
        sh_r <= {sh_r[6:0], sda_s};
      end
      if (decide) begin
        sda_oe_r <= ack_ok;
      end else if (load_tx) begin
        tx_r     <= rd_data_i;
        sda_oe_r <= !rd_data_i[7];
      end else if (ack_end) begin
        sda_oe_r <= 1'b0;
      end else if ((phase_r == ST_TX) && scl_fall) begin
        tx_r     <= {tx_r[6:0], 1'b0};
        sda_oe_r <= (bcnt_r == `EE_TX_LAST) ? 1'b0 : !tx_r[6];
      end
    end
  end

  // Word address counter; reset only at power-up, kept across transactions
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ahi_r  <= '0;
      addr_r <= '0;
    end else if (decide && ack_ok && (kind_r == KIND_AHI)) begin
      ahi_r <= sh_r[`EE_PAGE_W-1:0];
    end else if (decide && (kind_r == KIND_ALO)) begin
      addr_r <= {ahi_r, sh_r} & ADDR_MASK;
    end else if (push) begin
      addr_r <= inc_wr(addr_r);
    end else if (load_tx) begin
      addr_r <= inc_rd(addr_r);
    end
  end

  // Write capture and interval; a full FIFO refuses the byte with no ack
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wrote_r    <= 1'b0;
      busy_cnt_r <= '0;
    end else begin
      if (push) begin
        wrote_r <= 1'b1;
      end else if (stop_ev) begin
        wrote_r <= 1'b0;
      end
      if (stop_ev && wrote_r) begin
        busy_cnt_r <= TWR_LOAD;
      end else if (busy_cnt_r != '0) begin
        busy_cnt_r <= busy_cnt_r - 1'b1;
      end
    end
  end

  assign push_item = '{addr: addr_r, data: sh_r};

  stream_fifo #(
    .WIDTH ($bits(wr_item_type)),
    .DEPTH (`EE_FIFO_DEPTH)
  ) u_wr_fifo (
    .clk_sys_i   (clk_sys_i),
    .arst_n_i    (arst_n_i),
    .in_valid_i  (push),
    .in_ready_o  (fifo_rdy),
    .in_data_i   (push_item),
    .out_valid_o (wr_valid_o),
    .out_ready_i (wr_ready_i),
    .out_data_o  (wr_item_o)
  );

  // Open drain: the pin is only ever pulled low
  assign sda_o     = 1'b0;
  assign sda_oe_o  = sda_oe_r;
  assign rd_addr_o = addr_r;
  assign busy_o    = (busy_cnt_r != '0);

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);

  sequence s_rd_sel;
    decide && (kind_r == KIND_DEV) && dev_match && sh_r[0];
  endsequence
  sequence s_acking;
    (phase_r == ST_ACK) && sda_oe_r && rd_mode_r;
  endsequence

  rd_sel_ack_a: assert property (s_rd_sel |=> s_acking)
    else $error("read select not acknowledged");
  dev_nomatch_a: assert property (decide && (kind_r == KIND_DEV) && !dev_match
    |=> (phase_r == ST_IDLE) && !sda_oe_r)
    else $error("mismatched address not ignored");
  busy_nack_a: assert property (decide && (kind_r == KIND_DEV) && (busy_cnt_r != '0)
    |=> !sda_oe_r)
    else $error("address acknowledged during write interval");
  tx_bit_a: assert property ((phase_r == ST_TX) |-> (sda_oe_r == !tx_r[7]))
    else $error("data line does not match output bit");
  rd_wrap_a: assert property (load_tx && (addr_r == ADDR_MASK) |=> (addr_r == '0))
    else $error("read counter did not wrap to zero");
  rd_inc_a: assert property (load_tx |=> (addr_r == inc_rd($past(addr_r))))
    else $error("read counter did not step");
  wr_page_a: assert property (push |=> (addr_r[`EE_ADDR_W-1:`EE_PAGE_W] ==
    $past(addr_r[`EE_ADDR_W-1:`EE_PAGE_W])) && (addr_r[`EE_PAGE_W-1:0] ==
    $past(addr_r[`EE_PAGE_W-1:0]) + 1'b1))
    else $error("write counter left its page");
  addr_load_a: assert property (decide && (kind_r == KIND_ALO)
    |=> addr_r == ($past({ahi_r, sh_r}) & ADDR_MASK))
    else $error("word address not loaded");
  addr_keep_a: assert property ((phase_r == ST_IDLE) && !start_ev |=> $stable(addr_r))
    else $error("counter moved while idle");
  nack_release_a: assert property ((phase_r == ST_MACK) && scl_rise && sda_s && !stop_ev
    |=> (phase_r == ST_IDLE) && !sda_oe_r)
    else $error("line held after no-acknowledge");
  twr_load_a: assert property (stop_ev && wrote_r |=> busy_cnt_r == TWR_LOAD)
    else $error("write interval not started");
endmodule // serial_eeprom_read_engine

`default_nettype wire

// [hw/stream_fifo.sv]
// Valid/ready FIFO held in flip-flops; width and depth are parameters.
// Assumes one clock; DEPTH is a power of two.
`timescale 1ns/1ps
`default_nettype none

module stream_fifo #(
  parameter int WIDTH = 21,
  parameter int DEPTH = 16
) (
  input  wire logic             clk_sys_i,
  input  wire logic             arst_n_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0]      wr_ptr_r;
  logic [AW:0]      rd_ptr_r;
  logic             full;

  // Extra pointer bit tells full from empty
  assign full        = (wr_ptr_r[AW] != rd_ptr_r[AW]) &&
                       (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
  assign in_ready_o  = !full;
  assign out_valid_o = (wr_ptr_r != rd_ptr_r);
  assign out_data_o  = mem_r[rd_ptr_r[AW-1:0]];

  // Storage needs no reset; the pointers guard it
  always_ff @(posedge clk_sys_i) begin
    if (in_valid_i && !full) begin
      mem_r[wr_ptr_r[AW-1:0]] <= in_data_i;
    end
  end

  // Pointers
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      if (in_valid_i && !full) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (out_ready_i && out_valid_o) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
    end
  end
endmodule // stream_fifo

`default_nettype wire
